// ---- hw/irq_unit.sv ----
// sticky event status with enable and write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
`include "phy_regs_cfg.svh"
module irq_unit
   import phy_regs_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_b,
   irq_if.unit       ifc
);
   // --------------------------------------------------------------
   // sticky status: a set in the clear cycle wins
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         ifc.status <= '0;
      else if (ifc.wr_clr)
         ifc.status <= (ifc.status & ~ifc.wdata) | ifc.events;
      else
         ifc.status <= ifc.status | ifc.events;
   end

   // --------------------------------------------------------------
   // enable mask
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         ifc.enable <= '0;
      else if (ifc.wr_en)
         ifc.enable <= ifc.wdata;
   end
endmodule
`default_nettype wire

// ---- hw/phy_mode_status_registers.sv ----
// mode/status and 10 Mbps configuration registers of the transceiver
//
// Functional notes
// RULE_01: on negotiation completion the resolved mode lands in bits 15..12.
// RULE_02: the four resolved-mode flags are read-only and reset to one.
// RULE_03: software ignores the mode flags when negotiation is not in use.
// RULE_04: reserved bits read zero and drop written values.
// RULE_05: bits 8..4 hold the writable station address, reset from straps.
// RULE_06: the station address is matched msb first on management frames.
// RULE_07: the monitor field reports the nine documented negotiation codes.
// RULE_08: the monitor field is read-only and resets to zero.
// RULE_09: link-pulse enable resets to one; cleared it forces a good link. The code forces the good link only at 10 Mbps.
// RULE_10: heartbeat enable resets to one and gates the heartbeat function.
// RULE_11: heartbeat enable is ignored in full duplex.
// RULE_12: squelch select resets to one; one normal, zero low threshold.
// RULE_13: jabber enable resets to one, acting in 10 Mbps full or loopback.
// RULE_14: serial mode select is writable with its reset taken from a strap.
// RULE_15: software never selects serial mode while running at 100 Mbps.
// RULE_16: polarity flag follows the detector, read-only, resets to zero. The code holds the flag at zero at 100 Mbps.
// RULE_17: writes change only the writable fields of the addressed register.
`timescale 1ns/1ps
`default_nettype none
`include "phy_regs_cfg.svh"
module phy_mode_status_registers
   import phy_regs_pkg::*;
#(
   parameter int ADDR_W = `ADDR_W,
   parameter int DATA_W = `DATA_W
)
(
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic [4:0]        addr_strap,
   input  wire logic              serial_strap_low,
   input  wire logic              neg_complete,
   input  wire logic [3:0]        neg_result,
   input  wire logic [3:0]        neg_state,
   input  wire logic              neg_enabled,
   input  wire logic              pol_reversed_in,
   input  wire logic              speed_fast,
   input  wire logic              full_duplex,
   input  wire logic              loopback,
   input  wire logic              frame_addr_bit,
   input  wire logic              frame_addr_valid,
   input  wire logic              frame_addr_start,
   output logic                   frame_addr_match,
   output logic                   link_pulse_gen_on,
   output logic                   force_good_link,
   output logic                   heartbeat_active,
   output logic                   squelch_normal,
   output logic                   jabber_active,
   output logic                   serial_iface_select,
   output logic                   mode_flags_valid,
   output logic                   irq
);
   // widths are fixed by the register map; refuse anything else
   if (ADDR_W != 5 || DATA_W != 16)
   begin
      $error("phy_mode_status_registers: ADDR_W 5 and DATA_W 16 only");
   end

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   res_mode_s        res_mode;
   logic [4:0]       station_address_field;
   neg_code_e        negotiation_monitor_code;
   logic             heartbeat_on;
   logic             jabber_guard_on;
   logic             squelch_sel;
   logic             polarity_reversed_flag;
   logic             strap_taken;
   logic [4:0]       shift_addr;
   logic [2:0]       shift_cnt;
   logic             shift_ok;
   logic [DATA_W-1:0] next_rdata;
   logic             wr_neg;
   logic             wr_ten;
   logic             pol_prev;
   res_mode_s        mode_prev;

   irq_if irq_bus ();

   irq_unit u_irq
   (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .ifc     (irq_bus.unit)
   );

   // address decode, shared by writes and reads
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // unmapped offsets decode to nothing, so writes there are dropped
   assign wr_neg = reg_wr && hit(reg_addr, `NEG_STATUS_OFS);
   assign wr_ten = reg_wr && hit(reg_addr, `TEN_CFG_OFS);

   // --------------------------------------------------------------
   // resolved mode flags, hardware only
   // --------------------------------------------------------------
   // flags keep the last result until the next completion pulse
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         res_mode <= `MODE_RST;                  // see RULE_02
      else if (neg_complete)
         res_mode <= neg_result;                 // see RULE_01
   end

   // flags mean nothing outside negotiation; software must check this
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         mode_flags_valid <= 1'b0;
      else
         mode_flags_valid <= neg_enabled;        // see RULE_03
   end

   // --------------------------------------------------------------
   // monitor code, debug view of the negotiation state
   // --------------------------------------------------------------
   // undefined codes are dropped so the field never shows a value
   // the debug decoder cannot name; the last legal code stays
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         negotiation_monitor_code <= neg_idle;   // see RULE_08
      else if (neg_state <= neg_done)
         negotiation_monitor_code <= neg_code_e'(neg_state); // see RULE_07
   end

   // --------------------------------------------------------------
   // station address: strap taken one clock after reset release
   // --------------------------------------------------------------
   // a strap cannot be loaded under reset, so a clocked load follows it
   // a write in that first cycle loses to the strap load
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         strap_taken <= 1'b0;
      else
         strap_taken <= 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         station_address_field <= '0;
      else if (!strap_taken)
         station_address_field <= addr_strap;    // see RULE_05
      else if (wr_neg)
         station_address_field <= reg_wdata[`ADDR_HI:`ADDR_LO]; // see RULE_17
   end

   // --------------------------------------------------------------
   // 10 Mbps control bits
   // --------------------------------------------------------------
   // bits keep what software wrote at any speed; only the derived
   // outputs look at speed, so a rate change needs no rewrite
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         link_pulse_gen_on <= `CTRL_RST;         // see RULE_09
         heartbeat_on      <= `CTRL_RST;         // see RULE_10
         squelch_sel       <= `CTRL_RST;         // see RULE_12
         jabber_guard_on   <= `CTRL_RST;         // see RULE_13
      end
      else if (wr_ten)
      begin
         link_pulse_gen_on <= reg_wdata[`LP_BIT];
         heartbeat_on      <= reg_wdata[`HB_BIT];
         squelch_sel       <= reg_wdata[`SQ_BIT];
         jabber_guard_on   <= reg_wdata[`JAB_BIT];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         serial_iface_select <= 1'b0;
      else if (!strap_taken)
         serial_iface_select <= serial_strap_low; // see RULE_14
      else if (wr_ten)
         serial_iface_select <= reg_wdata[`SER_BIT];
   end

   // --------------------------------------------------------------
   // effective controls toward the datapath
   // --------------------------------------------------------------
   // one register stage behind the bits, so the datapath sees a write
   // two clocks after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         force_good_link  <= 1'b0;
         heartbeat_active <= 1'b0;
         squelch_normal   <= 1'b1;
         jabber_active    <= 1'b0;
      end
      else
      begin
         // pulse enable only counts at 10 Mbps
         force_good_link  <= !speed_fast && !link_pulse_gen_on; // see RULE_09
         heartbeat_active <= heartbeat_on && !full_duplex; // see RULE_11
         squelch_normal   <= squelch_sel;                  // see RULE_12
         jabber_active    <= jabber_guard_on && !speed_fast
                             && (full_duplex || loopback); // see RULE_13
      end
   end

   // --------------------------------------------------------------
   // polarity flag follows the detector
   // --------------------------------------------------------------
   // forced clear at 100 Mbps, where the 10 Mbps detector means nothing
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         polarity_reversed_flag <= `POL_RST;
      else
         polarity_reversed_flag <= pol_reversed_in && !speed_fast; // see RULE_16
   end

   // --------------------------------------------------------------
   // frame address matcher, msb arrives first
   // --------------------------------------------------------------
   // the counter stops at five so stray valid bits after the address
   // cannot disturb the captured value before the compare
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         shift_addr       <= '0;
         shift_cnt        <= '0;
         shift_ok         <= 1'b0;
         frame_addr_match <= 1'b0;
      end
      else if (frame_addr_start)
      begin
         shift_cnt        <= '0;
         shift_ok         <= 1'b0;
         frame_addr_match <= 1'b0;
      end
      else if (frame_addr_valid && shift_cnt != 3'd5)
      begin
         shift_addr <= {shift_addr[3:0], frame_addr_bit}; // see RULE_06
         shift_cnt  <= shift_cnt + 3'd1;
         if (shift_cnt == 3'd4)
            shift_ok <= 1'b1;
      end
      else if (shift_ok)
      begin
         shift_ok         <= 1'b0;
         frame_addr_match <= (shift_addr == station_address_field);
      end
   end

   // --------------------------------------------------------------
   // interrupt events: mode result, polarity change, completion
   // --------------------------------------------------------------
   // previous copies reset to the reset values, so leaving reset
   // raises no false change event
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         pol_prev  <= `POL_RST;
         mode_prev <= `MODE_RST;
      end
      else
      begin
         pol_prev  <= polarity_reversed_flag;
         mode_prev <= res_mode;
      end
   end

   always_comb
   begin
      irq_bus.events = '0;
      irq_bus.events[`INT_EV_MODE] = (res_mode != mode_prev);
      irq_bus.events[`INT_EV_POL]  = (polarity_reversed_flag != pol_prev);
      irq_bus.events[`INT_EV_DONE] = neg_complete;
   end

   assign irq_bus.wr_en  = reg_wr && hit(reg_addr, `INT_ENABLE_OFS);
   assign irq_bus.wr_clr = reg_wr && hit(reg_addr, `INT_CLEAR_OFS);
   assign irq_bus.wdata  = reg_wdata[`INT_BITS-1:0];

   // level output, registered so it comes from a flip-flop
   // costs one clock of interrupt latency, traded for a clean output
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         irq <= 1'b0;
      else
         irq <= |(irq_bus.status & irq_bus.enable);
   end

   // --------------------------------------------------------------
   // read mux; reserved and unmapped positions read zero
   // --------------------------------------------------------------
   // decoded from the live address so one register stage meets the
   // one-cycle read latency
   always_comb
   begin
      next_rdata = '0;                           // see RULE_04
      if (hit(reg_addr, `NEG_STATUS_OFS))
      begin
         next_rdata[`MODE_HI:`MODE_LO] = res_mode;
         next_rdata[`ADDR_HI:`ADDR_LO] = station_address_field;
         next_rdata[`MON_HI:`MON_LO]   = negotiation_monitor_code;
      end
      else if (hit(reg_addr, `TEN_CFG_OFS))
      begin
         next_rdata[`LP_BIT]  = link_pulse_gen_on;
         next_rdata[`HB_BIT]  = heartbeat_on;
         next_rdata[`SQ_BIT]  = squelch_sel;
         next_rdata[`JAB_BIT] = jabber_guard_on;
         next_rdata[`SER_BIT] = serial_iface_select; // see RULE_15
         next_rdata[`POL_BIT] = polarity_reversed_flag;
      end
      else if (hit(reg_addr, `INT_STATUS_OFS))
         next_rdata[`INT_BITS-1:0] = irq_bus.status;
      else if (hit(reg_addr, `INT_ENABLE_OFS))
         next_rdata[`INT_BITS-1:0] = irq_bus.enable;
   end

   // data valid only in the cycle after the strobe
   // cleared between reads so no stale word lingers on the bus
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         reg_rdata <= '0;
      else if (reg_rd)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= '0;
   end
endmodule
`default_nettype wire

// ---- inc/irq_if.sv ----
// event and interrupt signals between register bank and interrupt unit
`timescale 1ns/1ps
`default_nettype none
interface irq_if;
   logic [2:0] events;
   logic       wr_en;
   logic       wr_clr;
   logic [2:0] wdata;
   logic [2:0] status;
   logic [2:0] enable;
   modport bank (output events, output wr_en, output wr_clr, output wdata,
                 input status, input enable);
   modport unit (input events, input wr_en, input wr_clr, input wdata,
                 output status, output enable);
endinterface
`default_nettype wire

// ---- inc/phy_regs_cfg.svh ----
// offsets, field positions, reset values and sizes of the mode/status block
`ifndef PHY_REGS_CFG_SVH
`define PHY_REGS_CFG_SVH
`define NEG_STATUS_OFS      5'h11
`define TEN_CFG_OFS         5'h12
`define INT_STATUS_OFS      5'h1c
`define INT_ENABLE_OFS      5'h1d
`define INT_CLEAR_OFS       5'h1e
`define MODE_HI             15
`define MODE_LO             12
`define ADDR_HI             8
`define ADDR_LO             4
`define MON_HI              3
`define MON_LO              0
`define LP_BIT              14
`define HB_BIT              13
`define SQ_BIT              12
`define JAB_BIT             11
`define SER_BIT             10
`define POL_BIT             0
`define MODE_RST            4'hf
`define MON_RST             4'h0
`define CTRL_RST            1'b1
`define POL_RST             1'b0
`define INT_EV_MODE         0
`define INT_EV_POL          1
`define INT_EV_DONE         2
`define INT_BITS            3
`define ADDR_W              5
`define DATA_W              16
`endif

// ---- inc/phy_regs_pkg.sv ----
// types shared by the mode/status block
package phy_regs_pkg;
   typedef enum logic [3:0] {
      neg_idle        = 4'h0,
      neg_ability     = 4'h1,
      neg_ack         = 4'h2,
      neg_ack_fail    = 4'h3,
      neg_consist     = 4'h4,
      neg_consist_fail= 4'h5,
      neg_pd_ready    = 4'h6,
      neg_pd_fail     = 4'h7,
      neg_done        = 4'h8
   } neg_code_e;
   typedef struct packed {
      logic fast_full;
      logic fast_half;
      logic slow_full;
      logic slow_half;
   } res_mode_s;
endpackage

// ---- test/mgmt_frame_driver.sv ----
// management side model that shifts a station address into the matcher
`timescale 1ns/1ps
`default_nettype none
module mgmt_frame_driver
(
   input  wire logic sys_clk,
   output var logic  frame_addr_start,
   output var logic  frame_addr_valid,
   output var logic  frame_addr_bit
);
   // idle lines at time zero
   initial
   begin
      frame_addr_start = 1'b0;
      frame_addr_valid = 1'b0;
      frame_addr_bit   = 1'b0;
   end
   // start pulse, then five address bits, msb first
   task automatic send(input logic [4:0] a);
      @(posedge sys_clk);
      frame_addr_start <= 1'b1;
      @(posedge sys_clk);
      frame_addr_start <= 1'b0;
      for (int i = 4; i >= 0; i--)
      begin
         frame_addr_valid <= 1'b1;
         frame_addr_bit   <= a[i];
         @(posedge sys_clk);
      end
      frame_addr_valid <= 1'b0;
      frame_addr_bit   <= ~a[0]; // released line must not look valid
   endtask
endmodule
`default_nettype wire

// ---- test/phy_mode_status_registers_test.sv ----
// self-checking bench for the mode/status register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         n_fail++; \
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
      end \
   end
module phy_mode_status_registers_test
   import phy_regs_pkg::*;
;
   logic        sys_clk, rst_b, reg_wr, reg_rd, serial_strap_low;
   logic [4:0]  reg_addr, addr_strap;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic [3:0]  neg_result, neg_state;
   logic        neg_complete, neg_enabled, pol_reversed_in, speed_fast;
   logic        full_duplex, loopback, fa_bit, fa_valid, fa_start;
   logic        frame_addr_match, link_pulse_gen_on, force_good_link;
   logic        heartbeat_active, squelch_normal, jabber_active, irq;
   logic        serial_iface_select, mode_flags_valid;
   int          n_fail, n_compared, cycles;

   phy_mode_status_registers phy_mode_status_registers_inst (
      .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .addr_strap(addr_strap),
      .serial_strap_low(serial_strap_low), .neg_complete(neg_complete),
      .neg_result(neg_result), .neg_state(neg_state),
      .neg_enabled(neg_enabled), .pol_reversed_in(pol_reversed_in),
      .speed_fast(speed_fast), .full_duplex(full_duplex),
      .loopback(loopback), .frame_addr_bit(fa_bit),
      .frame_addr_valid(fa_valid), .frame_addr_start(fa_start),
      .frame_addr_match(frame_addr_match),
      .link_pulse_gen_on(link_pulse_gen_on),
      .force_good_link(force_good_link),
      .heartbeat_active(heartbeat_active),
      .squelch_normal(squelch_normal), .jabber_active(jabber_active),
      .serial_iface_select(serial_iface_select),
      .mode_flags_valid(mode_flags_valid), .irq(irq));
   mgmt_frame_driver mgmt_frame_driver_inst (.sys_clk(sys_clk),
      .frame_addr_start(fa_start), .frame_addr_valid(fa_valid),
      .frame_addr_bit(fa_bit));

   // ----------------------------------------
   // bus tasks and helpers
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   task automatic chk_rd(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] v;
      rd(a, v);
      `CHK(v, e)
   endtask
   task automatic pulse_neg(input logic [3:0] r);
      @(posedge sys_clk);
      neg_result   <= r;
      neg_complete <= 1'b1;
      @(posedge sys_clk);
      neg_complete <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // the whole run needs well under a thousand cycles
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t run timed out", $time);
         end_of_test();
      end
   end

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial
   begin
      {rst_b, reg_wr, reg_rd, neg_complete, neg_enabled} = '0;
      {pol_reversed_in, speed_fast, full_duplex, loopback} = '0;
      {reg_addr, reg_wdata, neg_result, neg_state} = '0;
      addr_strap       = 5'h15;
      serial_strap_low = 1'b1;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk_rd(5'h11, 16'hf150);
      chk_rd(5'h12, 16'h7c00);
      `CHK(heartbeat_active, 1'b1)
      `CHK(squelch_normal, 1'b1)
      `CHK(serial_iface_select, 1'b1)
      neg_enabled <= 1'b1;
      cyc(2);
      `CHK(mode_flags_valid, 1'b1)
      $display("test reset_values done");
      wr(5'h11, 16'hffff);
      chk_rd(5'h11, 16'hf1f0);
      wr(5'h12, 16'h0000);
      chk_rd(5'h12, 16'h0000);
      `CHK(force_good_link, 1'b1)
      `CHK(link_pulse_gen_on, 1'b0)
      `CHK(heartbeat_active, 1'b0)
      `CHK(squelch_normal, 1'b0)
      `CHK(serial_iface_select, 1'b0)
      wr(5'h12, 16'hffff);
      chk_rd(5'h12, 16'h7c00);
      full_duplex <= 1'b1;
      cyc(2);
      `CHK(heartbeat_active, 1'b0)
      `CHK(jabber_active, 1'b1)
      {full_duplex, loopback} <= 2'b01;
      wr(5'h12, 16'h7800);
      cyc(2);
      `CHK(jabber_active, 1'b1)
      speed_fast <= 1'b1;
      cyc(2);
      `CHK(jabber_active, 1'b0)
      {speed_fast, loopback} <= 2'b00;
      $display("test field_access done");
      for (int i = 0; i < 4; i++)
      begin
         pulse_neg(4'h1 << i);
         chk_rd(5'h11, {4'h1 << i, 12'h1f0});
      end
      for (int c = 0; c < 10; c++)
      begin
         neg_state <= 4'(c);
         cyc(2);
         rd(5'h11, d);
         `CHK(d[3:0], (c > 8) ? 4'h8 : 4'(c))
      end
      wr(5'h11, 16'h0000);
      chk_rd(5'h11, 16'h8008);
      $display("test negotiation done");
      pol_reversed_in <= 1'b1;
      cyc(2);
      chk_rd(5'h12, 16'h7801);
      pol_reversed_in <= 1'b0;
      cyc(2);
      chk_rd(5'h12, 16'h7800);
      $display("test polarity done");
      wr(5'h1e, 16'h0007);
      wr(5'h1d, 16'h0004);
      cyc(3);
      `CHK(irq, 1'b0)
      pulse_neg(4'h8);
      cyc(3);
      `CHK(irq, 1'b1)
      rd(5'h1c, d);
      `CHK(d[2], 1'b1)
      wr(5'h1e, 16'h0007);
      cyc(3);
      `CHK(irq, 1'b0)
      wr(5'h1d, 16'h0000);
      pulse_neg(4'h4);
      cyc(3);
      `CHK(irq, 1'b0)
      chk_rd(5'h05, 16'h0000);
      $display("test interrupts done");
      wr(5'h11, 16'h0130);
      mgmt_frame_driver_inst.send(5'h13);
      cyc(2);
      `CHK(frame_addr_match, 1'b1)
      mgmt_frame_driver_inst.send(5'h19);
      cyc(2);
      `CHK(frame_addr_match, 1'b0)
      $display("test address_match done");
      serial_strap_low <= 1'b0;
      addr_strap       <= 5'h0a;
      rst_b            <= 1'b0;
      cyc(2);
      rst_b <= 1'b1;
      cyc(2);
      chk_rd(5'h11, 16'hf0a0);
      chk_rd(5'h12, 16'h7800);
      $display("test strap_reload done");
      end_of_test();
   end
endmodule
`default_nettype wire

// ---- test/phy_regs_properties.sv ----
// concurrent checks on the ports of the mode/status register block
`timescale 1ns/1ps
`default_nettype none
module phy_regs_properties
   import phy_regs_pkg::*;
#(
   parameter int ADDR_W = 5,
   parameter int DATA_W = 16
)
(
   input wire logic              sys_clk,
   input wire logic              rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              neg_enabled,
   input wire logic              speed_fast,
   input wire logic              full_duplex,
   input wire logic              frame_addr_start,
   input wire logic              frame_addr_match,
   input wire logic              force_good_link,
   input wire logic              heartbeat_active,
   input wire logic              squelch_normal,
   input wire logic              jabber_active,
   input wire logic              serial_iface_select,
   input wire logic              mode_flags_valid
);
   // ----------------------------------------
   // single clock domain, sync reset
   // ----------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   // one-cycle register accesses
   sequence s_read(logic [ADDR_W-1:0] a);
      reg_rd && reg_addr == a;
   endsequence
   sequence s_write(logic [ADDR_W-1:0] a);
      reg_wr && reg_addr == a;
   endsequence

   // ----------------------------------------
   // read data and control outputs
   // ----------------------------------------
   a_mode_reserved_zero: assert property (
      s_read(5'h11) |=> reg_rdata[11:9] == 3'h0)
      else $error("reserved bits of mode register read nonzero");
   a_ten_reserved_zero: assert property (
      s_read(5'h12) |=> reg_rdata[15] == 1'b0 && reg_rdata[9:1] == 9'h0)
      else $error("reserved bits of 10M register read nonzero");
   a_monitor_code_legal: assert property (
      s_read(5'h11) |=> reg_rdata[3:0] <= 4'h8)
      else $error("monitor field shows an undefined code");
   a_heartbeat_fdx_off: assert property (
      full_duplex |=> !heartbeat_active)
      else $error("heartbeat active in full duplex");
   a_jabber_fast_off: assert property (
      speed_fast |=> !jabber_active)
      else $error("jabber active at 100M");
   a_force_link_slow: assert property (
      speed_fast |=> !force_good_link)
      else $error("good link forced at 100M");
   a_mode_valid_follow: assert property (
      1'b1 |=> mode_flags_valid == $past(neg_enabled))
      else $error("mode valid does not follow negotiation enable");
   a_squelch_write_out: assert property (
      s_write(5'h12) |-> ##2 squelch_normal == $past(reg_wdata[12], 2))
      else $error("squelch output ignores written value");
   a_serial_write_out: assert property (
      s_write(5'h12) |-> ##2 serial_iface_select == $past(reg_wdata[10], 2))
      else $error("serial select output ignores written value");
   a_match_clear_start: assert property (
      frame_addr_start |=> !frame_addr_match)
      else $error("address match not cleared by frame start");
endmodule
bind phy_mode_status_registers phy_regs_properties
   #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) props_inst
   (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .neg_enabled(neg_enabled),
    .speed_fast(speed_fast), .full_duplex(full_duplex),
    .frame_addr_start(frame_addr_start),
    .frame_addr_match(frame_addr_match),
    .force_good_link(force_good_link),
    .heartbeat_active(heartbeat_active),
    .squelch_normal(squelch_normal), .jabber_active(jabber_active),
    .serial_iface_select(serial_iface_select),
    .mode_flags_valid(mode_flags_valid));
`default_nettype wire
